// ==== pkg/afs_defines.svh ====
// Register offsets, field positions, reset values and bus codes of the bridge
`ifndef AFS_DEFINES_SVH
`define AFS_DEFINES_SVH
`define AFS_REG_CTRL             4'h0
`define AFS_REG_NB_BASE          4'h4
`define AFS_REG_NB_MASK          4'h8
`define AFS_REG_STATUS           4'hC
`define AFS_CTRL_BUF_EN_BIT      0
`define AFS_CTRL_NB_EN_BIT       1
`define AFS_CTRL_RESET           2'h1
`define AFS_NB_BASE_RESET        32'h0000_0000
`define AFS_NB_MASK_RESET        32'h0000_0000
`define AFS_STAT_SLOW_BUSY_BIT   0
`define AFS_STAT_BUF_BUSY_BIT    1
`define AFS_STAT_ERRCNT_LSB      8
`define AFS_TRANS_IDLE           2'h0
`define AFS_TRANS_BUSY           2'h1
`define AFS_TRANS_NONSEQ         2'h2
`define AFS_TRANS_SEQ            2'h3
`define AFS_BURST_SINGLE         3'h0
`define AFS_HPROT_BUFFERABLE_BIT 2
`endif

// ==== pkg/afs_link_if.sv ====
// Carrier between the bridge core, its error responder and its burst mapper
`default_nettype none
interface afs_link_if;
   import afs_pkg::*;
   logic       errStart;
   logic       errResp;
   logic       errWait;
   afs_trans_t rawTrans;
   afs_trans_t mapTrans;
   afs_burst_t rawBurst;
   afs_burst_t mapBurst;
   modport core (output errStart, rawTrans, rawBurst,
                 input  errResp, errWait, mapTrans, mapBurst);
   modport errgen (input errStart, output errResp, errWait);
   modport bmap (input rawTrans, rawBurst, output mapTrans, mapBurst);
endinterface
`default_nettype wire

// ==== pkg/afs_pkg.sv ====
// Types shared by the bridge modules
`default_nettype none
package afs_pkg;
   typedef enum {FAST_IDLE, FAST_WAIT} afs_fast_state_t;
   typedef enum {SLOW_IDLE, SLOW_ADDR, SLOW_DATA} afs_slow_state_t;
   typedef logic [1:0] afs_trans_t;
   typedef logic [2:0] afs_burst_t;
endpackage
`default_nettype wire

// ==== rtl/afs_bridge.sv ====
// AHB fast-to-slow bridge with optional write buffer and register slave
//
// Implementation choices: the register offsets and the Avalon-MM interface to the registers.
`include "afs_defines.svh"
`default_nettype none
module afs_bridge
   import afs_pkg::*;
#(
   parameter int address_width_param        = 32,
   parameter int data_width_param           = 32,
   parameter int master_id_width_param      = 1,
   parameter bit burst_support_param        = 1'b0,
   parameter bit write_buffer_present_param = 1'b0,
   parameter bit mask_read_data_param       = 1'b1
)(
   input  wire logic                             mclk,
   input  wire logic                             nrst,
   input  wire logic                             slow_cycle_enable,
   input  wire logic                             exclStore,
   input  wire logic                             hsel,
   input  wire logic [address_width_param-1:0]   haddr,
   input  wire logic [1:0]                       htrans,
   input  wire logic [2:0]                       hsize,
   input  wire logic                             hwrite,
   input  wire logic [2:0]                       hburst,
   input  wire logic [3:0]                       hprot,
   input  wire logic [master_id_width_param-1:0] hmaster,
   input  wire logic                             hmastlock,
   input  wire logic [data_width_param-1:0]      hwdata,
   input  wire logic                             hready,
   output logic      [data_width_param-1:0]      upstream_read_data,
   output logic                                  upstream_ready_out,
   output logic                                  upstream_response,
   output logic      [address_width_param-1:0]   haddrM,
   output logic      [1:0]                       htransM,
   output logic      [2:0]                       hsizeM,
   output logic                                  hwriteM,
   output logic      [2:0]                       hburstM,
   output logic      [3:0]                       hprotM,
   output logic      [master_id_width_param-1:0] hmasterM,
   output logic                                  hmastlockM,
   output logic      [data_width_param-1:0]      hwdataM,
   input  wire logic [data_width_param-1:0]      hrdataM,
   input  wire logic                             hreadyM,
   input  wire logic                             hrespM,
   output logic                                  buffered_write_error_pulse,
   input  wire logic [3:0]                       avAddress,
   input  wire logic                             avRead,
   input  wire logic                             avWrite,
   input  wire logic [31:0]                      avWriteData,
   input  wire logic [3:0]                       avByteEnable,
   output logic      [31:0]                      avReadData,
   output logic                                  avWaitRequest
);
   afs_link_if lnk ();

   afs_err_resp u_err (
      .mclk (mclk),
      .nrst (nrst),
      .lnk  (lnk)
   );

   afs_burst_map #(.burst_support_param(burst_support_param)) u_bmap (
      .lnk (lnk)
   );

   afs_fast_state_t                  fastState;
   afs_slow_state_t                  slowState;
   logic [address_width_param-1:0]   holdAddr;
   logic [1:0]                       holdTrans;
   logic [2:0]                       holdSize;
   logic                             holdWrite;
   logic [2:0]                       holdBurst;
   logic [3:0]                       holdProt;
   logic [master_id_width_param-1:0] holdMaster;
   logic                             holdLock;
   logic                             holdBuf;
   logic                             issued;
   logic                             slowBuf;
   logic [1:0]                       ctrl;
   logic [31:0]                      nbBase;
   logic [31:0]                      nbMask;
   logic [7:0]                       errCount;
   logic [31:0]                      byteMask;
   logic [31:0]                      statusWord;
   logic                             accept;
   logic                             nbHit;
   logic                             bufferable;
   logic                             issue;
   logic                             slowDone;
   logic                             readyWait;
   logic                             fastReady;
   logic                             regWrite;

   assign accept = hsel && htrans[1] && hready;
   assign nbHit  = ctrl[`AFS_CTRL_NB_EN_BIT] &&
                   (((haddr ^ nbBase[address_width_param-1:0]) &
                     nbMask[address_width_param-1:0]) == '0);
   // Buffering only when built in, enabled, a posted-safe write, not exclusive and outside the non-bufferable region
   assign bufferable = write_buffer_present_param && ctrl[`AFS_CTRL_BUF_EN_BIT] &&
                       hwrite && hprot[`AFS_HPROT_BUFFERABLE_BIT] &&
                       !exclStore && !nbHit;

   // Issue waits for an idle slow bus, so a second transfer stays held
   assign issue    = (fastState == FAST_WAIT) && !issued && (slowState == SLOW_IDLE);
   assign slowDone = slow_cycle_enable && hreadyM && (slowState == SLOW_DATA);

   // Buffered write answers when it leaves for the slow side
   assign readyWait = holdBuf ? issue : (issued && slowDone && !hrespM);
   assign lnk.errStart = (fastState == FAST_WAIT) && !holdBuf && issued &&
                         slowDone && hrespM;
   assign lnk.rawTrans = holdTrans;
   assign lnk.rawBurst = holdBurst;

   always_comb begin
      if (lnk.errResp) begin
         fastReady = !lnk.errWait;
      end else if (fastState == FAST_IDLE) begin
         fastReady = 1'b1;
      end else begin
         fastReady = readyWait;
      end
   end

   // Ready and read data are combinational so slow completion costs no fast cycle
   assign upstream_ready_out = fastReady;
   assign upstream_read_data = (mask_read_data_param && !fastReady) ?
                               '0 : hrdataM;
   assign upstream_response  = lnk.errResp;

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         fastState <= FAST_IDLE;
      end else if (accept && (fastState == FAST_IDLE || readyWait || lnk.errResp)) begin
         fastState <= FAST_WAIT;
      end else if (fastState == FAST_WAIT && (readyWait || lnk.errStart)) begin
         fastState <= FAST_IDLE;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         holdAddr   <= '0;
         holdTrans  <= `AFS_TRANS_IDLE;
         holdSize   <= 3'h0;
         holdWrite  <= 1'b0;
         holdBurst  <= `AFS_BURST_SINGLE;
         holdProt   <= 4'h0;
         holdMaster <= '0;
         holdLock   <= 1'b0;
         holdBuf    <= 1'b0;
      end else if (accept) begin
         holdAddr   <= haddr;
         holdTrans  <= htrans;
         holdSize   <= hsize;
         holdWrite  <= hwrite;
         holdBurst  <= hburst;
         holdProt   <= hprot;
         holdMaster <= hmaster;
         holdLock   <= hmastlock;
         holdBuf    <= bufferable;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         issued <= 1'b0;
      end else if (accept) begin
         issued <= 1'b0;
      end else if (issue) begin
         issued <= 1'b1;
      end
   end

   // Slow side; a new address phase may be loaded at any edge, advancing needs enable
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         slowState  <= SLOW_IDLE;
         haddrM     <= '0;
         htransM    <= `AFS_TRANS_IDLE;
         hsizeM     <= 3'h0;
         hwriteM    <= 1'b0;
         hburstM    <= `AFS_BURST_SINGLE;
         hprotM     <= 4'h0;
         hmasterM   <= '0;
         hmastlockM <= 1'b0;
         hwdataM    <= '0;
         slowBuf    <= 1'b0;
      end else begin
         case (slowState)
            SLOW_IDLE: begin
               if (issue) begin
                  slowState  <= SLOW_ADDR;
                  haddrM     <= holdAddr;
                  htransM    <= lnk.mapTrans;
                  hsizeM     <= holdSize;
                  hwriteM    <= holdWrite;
                  hburstM    <= lnk.mapBurst;
                  hprotM     <= holdProt;
                  hmasterM   <= holdMaster;
                  hmastlockM <= holdLock;
                  slowBuf    <= holdBuf;
                  // Master holds its write data until answered, so it is safe here
                  if (holdWrite) begin
                     hwdataM <= hwdata;
                  end
               end
            end
            SLOW_ADDR: begin
               if (slow_cycle_enable && hreadyM) begin
                  slowState <= SLOW_DATA;
                  // Park inside a forwarded burst rather than break it
                  htransM   <= (hburstM != `AFS_BURST_SINGLE) ?
                               `AFS_TRANS_BUSY : `AFS_TRANS_IDLE;
               end
            end
            SLOW_DATA: begin
               if (slowDone) begin
                  slowState <= SLOW_IDLE;
               end
            end
            default: begin
               slowState <= SLOW_IDLE;
            end
         endcase
      end
   end

   // Posted write failed after its OKAY; only an event is left to report
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         buffered_write_error_pulse <= 1'b0;
      end else begin
         buffered_write_error_pulse <= slowDone && hrespM && slowBuf;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         errCount <= 8'h00;
      end else if (slowDone && hrespM && slowBuf) begin
         errCount <= errCount + 8'h01;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_be
         assign byteMask[gi*8 +: 8] = {8{avByteEnable[gi]}};
      end
   endgenerate

   always_comb begin
      statusWord = 32'h0000_0000;
      statusWord[`AFS_STAT_SLOW_BUSY_BIT] = (slowState != SLOW_IDLE);
      statusWord[`AFS_STAT_BUF_BUSY_BIT]  = (slowState != SLOW_IDLE) && slowBuf;
      statusWord[`AFS_STAT_ERRCNT_LSB +: 8] = errCount;
   end

   // One wait cycle per access keeps read data a clean flop output
   assign regWrite = avWrite && !avWaitRequest;

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         avWaitRequest <= 1'b1;
      end else begin
         avWaitRequest <= !((avRead || avWrite) && avWaitRequest);
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         avReadData <= 32'h0000_0000;
      end else if (avRead && avWaitRequest) begin
         case (avAddress)
            `AFS_REG_CTRL:    avReadData <= {30'h0000_0000, ctrl};
            `AFS_REG_NB_BASE: avReadData <= nbBase;
            `AFS_REG_NB_MASK: avReadData <= nbMask;
            `AFS_REG_STATUS:  avReadData <= statusWord;
            default:          avReadData <= 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         ctrl   <= `AFS_CTRL_RESET;
         nbBase <= `AFS_NB_BASE_RESET;
         nbMask <= `AFS_NB_MASK_RESET;
      end else if (regWrite) begin
         case (avAddress)
            `AFS_REG_CTRL: begin
               if (avByteEnable[0]) begin
                  ctrl <= avWriteData[1:0];
               end
            end
            `AFS_REG_NB_BASE: nbBase <= (nbBase & ~byteMask) | (avWriteData & byteMask);
            `AFS_REG_NB_MASK: nbMask <= (nbMask & ~byteMask) | (avWriteData & byteMask);
            default: begin
            end
         endcase
      end
   end

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!nrst);

   a_width_legal:
   assert property (data_width_param == 32 || data_width_param == 64)
      else $error("data width must be 32 or 64");

   a_fwd_registered:
   assert property (!$stable(haddrM) |-> $past(issue))
      else $error("slow address changed without an issue");

   a_fwd_latency:
   assert property ($rose(slowState == SLOW_ADDR) |-> $past(fastState == FAST_WAIT))
      else $error("slow address phase without a held fast transfer");

   a_slow_gated:
   assert property ((slowState != SLOW_IDLE) && !slow_cycle_enable
                    |=> slowState == $past(slowState))
      else $error("slow state moved without enable");

   a_ready_pass:
   assert property ((fastState == FAST_WAIT) && issued && !holdBuf && !lnk.errResp
                    |-> upstream_ready_out == (slowDone && !hrespM))
      else $error("ready does not follow slow completion");

   a_err_two_cycle:
   assert property (lnk.errStart |=> (upstream_response && !upstream_ready_out)
                    ##1 (upstream_response && upstream_ready_out))
      else $error("error response not two registered cycles");

   a_unbuf_stall:
   assert property ((fastState == FAST_WAIT) && !holdBuf && !lnk.errResp
                    && !slowDone |-> !upstream_ready_out)
      else $error("unbuffered transfer answered early");

   a_held_stall:
   assert property ((fastState == FAST_WAIT) && !issued && (slowState != SLOW_IDLE)
                    |-> !upstream_ready_out)
      else $error("held transfer answered while slow busy");

   a_buf_okay:
   assert property ((fastState == FAST_WAIT) && holdBuf && issue
                    |-> upstream_ready_out && !upstream_response)
      else $error("buffered write not answered OKAY on issue");

   a_excl_unbuf:
   assert property (accept && exclStore |=> !holdBuf)
      else $error("exclusive store was buffered");

   a_read_unbuf:
   assert property (accept && !hwrite |=> !holdBuf)
      else $error("read treated as bufferable");

   a_buffered_write_error_pulse_pulse:
   assert property (buffered_write_error_pulse |-> $past(slowDone && hrespM && slowBuf)
                    ##1 !buffered_write_error_pulse)
      else $error("buffered write error pulse wrong");

   a_rdata_mask:
   assert property (mask_read_data_param && !upstream_ready_out
                    |-> upstream_read_data == '0)
      else $error("read data not masked while stalled");

   a_burst_single:
   assert property (!burst_support_param |-> htransM != `AFS_TRANS_SEQ
                    && hburstM == `AFS_BURST_SINGLE)
      else $error("burst leaked with burst support off");
endmodule // afs_bridge
`default_nettype wire

// ==== rtl/afs_burst_map.sv ====
// Burst pass-through or conversion to single transfers
`include "afs_defines.svh"
`default_nettype none
module afs_burst_map
   import afs_pkg::*;
#(
   parameter bit burst_support_param = 1'b0
)(
   afs_link_if.bmap lnk
);
   generate
      if (burst_support_param) begin : g_pass
         assign lnk.mapTrans = lnk.rawTrans;
         assign lnk.mapBurst = lnk.rawBurst;
      end else begin : g_single
         // Every beat leaves as its own NONSEQ single
         assign lnk.mapTrans = `AFS_TRANS_NONSEQ;
         assign lnk.mapBurst = `AFS_BURST_SINGLE;
      end
   endgenerate
endmodule // afs_burst_map
`default_nettype wire

// ==== rtl/afs_err_resp.sv ====
// Registered two-cycle error response toward the fast segment
`default_nettype none
module afs_err_resp
   import afs_pkg::*;
(
   input  wire logic mclk,
   input  wire logic nrst,
   afs_link_if.errgen lnk
);
   // First cycle holds ready low, second raises it, both flag the error
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         lnk.errWait <= 1'b0;
         lnk.errResp <= 1'b0;
      end else begin
         lnk.errWait <= lnk.errStart;
         lnk.errResp <= lnk.errStart | lnk.errWait;
      end
   end
endmodule // afs_err_resp
`default_nettype wire

// ==== verification/afs_slow_slave.sv ====
// Behavioural slave segment on the slow side of the bridge
`default_nettype none
module afs_slow_slave (
   input  wire logic        mclk,
   input  wire logic        nrst,
   input  wire logic        en,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [31:0] hwdata,
   input  wire logic [1:0]  waits,
   output logic      [31:0] hrdata,
   output logic             hready,
   output logic             hresp
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [31:0] mem [16];
   logic [31:0] junk;
   logic [3:0]  idx;
   logic [1:0]  wc;
   logic        dp, wr, err, es;
   // Address bit 8 answers with the two-cycle error
   assign hready = !dp || (wc == 2'h0 && (!err || es));
   assign hresp  = dp && err;
   // Outside a read completion the data lines never hold the last value
   assign hrdata = (dp && hready && !wr) ? mem[idx] : junk;
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         dp <= 1'b0; wr <= 1'b0; err <= 1'b0; es <= 1'b0;
         wc <= 2'h0; idx <= 4'h0; junk <= 32'h0;
      end else begin
         junk <= junk + 32'h9E37_79B9;
         if (en) begin
            if (dp && hready) begin
               if (wr && !err) mem[idx] <= hwdata;
               dp <= 1'b0;
            end else if (dp && wc != 2'h0) wc <= wc - 2'h1;
            else if (dp) es <= 1'b1;
            if (htrans[1] && hready) begin
               dp <= 1'b1; wr <= hwrite; err <= haddr[8]; es <= 1'b0;
               idx <= haddr[5:2]; wc <= waits;
            end
         end
      end
   end
endmodule // afs_slow_slave
`default_nettype wire

// ==== verification/tb.sv ====
// Self-checking bench of the fast to slow bridge
`default_nettype none
module tb;
   import afs_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {logic [31:0] d; logic rd; logic er; int ew;} afs_exp_t;
   logic        mclk, nrst, en, excl, hsel, hwrite, dPhase, avRead, avWrite, rdyS, wrS;
   logic        rdy, resp, hwriteM, hreadyM, hrespM, bwe, avWait, hmasterM, hmastlockM;
   logic [31:0] haddr, hwdata, avWd, lf, rdata, haddrM, hwdataM, hrdataM, avRd;
   logic [1:0]  htrans, htransM, waits;
   logic [2:0]  hburst, hburstM, hsizeM;
   logic [3:0]  hprot, avAddr, avBe, hprotM;
   logic [31:0] dq [4];
   afs_exp_t    expQ [$];
   logic [31:0] avQ [$];
   afs_exp_t    e;
   int          numErrors, samplesChecked, waitN, pulseLen, pulses, ratio, cnt;

   afs_bridge #(.write_buffer_present_param(1'b1)) dut (.mclk(mclk), .nrst(nrst),
      .slow_cycle_enable(en), .exclStore(excl), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hsize(3'h2), .hwrite(hwrite), .hburst(hburst), .hprot(hprot),
      .hmaster(1'b0), .hmastlock(1'b0), .hwdata(hwdata), .hready(rdy),
      .upstream_read_data(rdata), .upstream_ready_out(rdy), .upstream_response(resp),
      .haddrM(haddrM), .htransM(htransM), .hsizeM(hsizeM), .hwriteM(hwriteM),
      .hburstM(hburstM), .hprotM(hprotM), .hmasterM(hmasterM), .hmastlockM(hmastlockM),
      .hwdataM(hwdataM), .hrdataM(hrdataM),
      .hreadyM(hreadyM), .hrespM(hrespM), .buffered_write_error_pulse(bwe),
      .avAddress(avAddr), .avRead(avRead), .avWrite(avWrite), .avWriteData(avWd),
      .avByteEnable(avBe), .avReadData(avRd), .avWaitRequest(avWait));
   afs_slow_slave slave (.mclk(mclk), .nrst(nrst), .en(en), .haddr(haddrM),
      .htrans(htransM), .hwrite(hwriteM), .hwdata(hwdataM), .waits(waits),
      .hrdata(hrdataM), .hready(hreadyM), .hresp(hrespM));

   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   // Enable from a counter on the one clock
   always @(posedge mclk) begin
      cnt <= (cnt >= ratio - 1) ? 0 : cnt + 1;
      en  <= (cnt >= ratio - 1);
   end

   function automatic logic [31:0] nextRnd(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samplesChecked++;
      if (seen !== exp) begin
         numErrors++;
         $display("[FAIL] %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic endOfTest;
      $display("Checks %0d, mismatches %0d", samplesChecked, numErrors);
      if (numErrors == 0 && samplesChecked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic avXfer(input logic rd, input logic [3:0] a, input logic [31:0] d);
      int n;
      if (rd) avQ.push_back(d);
      avAddr <= a; avRead <= rd; avWrite <= !rd; avWd <= d; avBe <= 4'hF;
      n = 0;
      do begin @(posedge mclk); n++; end while (wrS && n < 50);
      if (n >= 50) begin numErrors++; endOfTest; end
      else begin avRead <= 1'b0; avWrite <= 1'b0; @(posedge mclk); end
   endtask
   // ew: exact wait states, or -1 for any stall
   task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d,
                      input logic [1:0] tr, input logic bf, input logic er, input int ew);
      int n;
      expQ.push_back('{d, !wr, er, ew});
      hsel <= 1'b1; htrans <= tr; haddr <= a; hwrite <= wr; hprot <= {1'b0, bf, 2'h3};
      @(posedge mclk);
      hsel <= (hburst != 3'h0); htrans <= (hburst != 3'h0) ? 2'h1 : 2'h0;
      hwdata <= d; excl <= 1'b0; dPhase <= 1'b1;
      n = 0;
      do begin @(posedge mclk); n++; end while (!rdyS && n < 200);
      if (n >= 200) begin numErrors++; endOfTest; end
      else begin dPhase <= 1'b0; hwdata <= ~d; end
   endtask

   // Watches outputs mid-cycle, where they are settled
   always @(negedge mclk) begin
      rdyS = rdy;
      wrS = avWait;
      if (htransM[1]) begin
         check(32'({hburstM, htransM}), 32'h2);
         check(32'({hmastlockM, hmasterM, hprotM[3], hprotM[1:0], hsizeM}), 32'h1A);
      end
      if (avRead && !avWait) check(avRd, avQ.pop_front());
      if (bwe) pulseLen++;
      else if (pulseLen != 0) begin check(pulseLen, 1); pulses++; pulseLen = 0; end
      if (dPhase && !rdy) begin
         check(rdata, 32'h0);
         waitN++;
      end else if (dPhase && expQ.size() > 0) begin
         e = expQ.pop_front();
         check(32'(resp), 32'(e.er));
         if (e.ew < 0) check(32'(waitN > 0), 32'h1);
         else check(waitN, e.ew);
         if (e.rd && !e.er) check(rdata, e.d);
         waitN = 0;
      end
   end

   initial begin
      nrst = 1'b0; en = 1'b0; cnt = 0; ratio = 1; excl = 1'b0; hsel = 1'b0; hwrite = 1'b0;
      htrans = 2'h0; hburst = 3'h0; hprot = 4'h0; haddr = 32'h0; hwdata = 32'h0;
      avAddr = 4'h0; avRead = 1'b0; avWrite = 1'b0; avWd = 32'h0; avBe = 4'hF;
      waits = 2'h0; dPhase = 1'b0; lf = 32'h2689; waitN = 0; pulseLen = 0; pulses = 0;
      numErrors = 0; samplesChecked = 0; rdyS = 1'b1; wrS = 1'b1;
      repeat (16) @(posedge mclk);
      nrst <= 1'b1;
      for (int i = 0; i < 4; i++) avXfer(1'b1, 4'(i * 4), (i == 0) ? 32'h1 : 32'h0);
      avXfer(1'b0, 4'h2, 32'hFFFF_FFFF);
      avXfer(1'b1, 4'h2, 32'h0);
      $display("Register reset test done");
      ahb(1'b1, 32'h40, 32'hA5A5_0001, 2'h2, 1'b0, 1'b0, -1);
      ahb(1'b0, 32'h40, 32'hA5A5_0001, 2'h2, 1'b0, 1'b0, 2);
      $display("Same rate test done");
      ratio = 3;
      for (int i = 0; i < 4; i++) begin
         lf = nextRnd(lf); dq[i] = lf; waits <= lf[1:0];
         ahb(1'b1, 32'h40 + 32'(i * 4), lf, 2'h2, 1'b0, 1'b0, -1);
      end
      for (int i = 0; i < 4; i++) ahb(1'b0, 32'h40 + 32'(i * 4), dq[i], 2'h2, 1'b0, 1'b0, -1);
      hburst <= 3'h3;
      for (int i = 0; i < 4; i++) ahb(1'b1, 32'h50 + 32'(i * 4), dq[i], (i == 0) ? 2'h2 : 2'h3,
                                      1'b0, 1'b0, -1);
      hburst <= 3'h0;
      ahb(1'b0, 32'h5C, dq[3], 2'h2, 1'b0, 1'b0, -1);
      $display("Ratio and burst test done");
      repeat (12) @(posedge mclk);
      ahb(1'b1, 32'h60, dq[0], 2'h2, 1'b1, 1'b0, 0);
      ahb(1'b1, 32'h64, dq[1], 2'h2, 1'b1, 1'b0, -1);
      ahb(1'b0, 32'h60, dq[0], 2'h2, 1'b1, 1'b0, -1);
      ahb(1'b0, 32'h64, dq[1], 2'h2, 1'b1, 1'b0, -1);
      repeat (12) @(posedge mclk);
      excl <= 1'b1;
      ahb(1'b1, 32'h68, dq[2], 2'h2, 1'b1, 1'b0, -1);
      $display("Write buffer test done");
      repeat (12) @(posedge mclk);
      pulses = 0;
      ahb(1'b1, 32'h100, dq[3], 2'h2, 1'b1, 1'b0, 0);
      repeat (30) @(posedge mclk);
      check(pulses, 1);
      ahb(1'b0, 32'h100, 32'h0, 2'h2, 1'b0, 1'b1, -1);
      avXfer(1'b1, 4'hC, 32'h100);
      $display("Error test done");
      avXfer(1'b0, 4'h4, 32'h40);
      avXfer(1'b0, 4'h8, 32'hFFFF_FFF0);
      avXfer(1'b0, 4'h0, 32'h3);
      avXfer(1'b1, 4'h4, 32'h40);
      repeat (12) @(posedge mclk);
      ahb(1'b1, 32'h44, dq[0], 2'h2, 1'b1, 1'b0, -1);
      repeat (12) @(posedge mclk);
      ahb(1'b1, 32'h80, dq[1], 2'h2, 1'b1, 1'b0, 0);
      avXfer(1'b0, 4'h0, 32'h0);
      repeat (12) @(posedge mclk);
      ahb(1'b1, 32'h84, dq[2], 2'h2, 1'b1, 1'b0, -1);
      $display("Non-bufferable region test done");
      endOfTest;
   end
endmodule // tb
`default_nettype wire
